/* File: core/emisc_top.sv */
// external memory cycle strobes and internal configuration scan
//
// How it works
// - width strobe ends by phase six; zero never
// - delayed strobes 0..31, forced high after five
// - width strobe active 0..31 half periods
// - cycle is phases one to six plus waits
// - frame strobe low phases two to five
// - four byte write strobes, zero is low
// - unwritten byte lanes tristated during writes
// - late write four-five, early adds three
// - extra phase periods lengthen strobes or hold
// - waits inserted end of phase four
// - no write strobes on on-chip cycles
// - after reset internal scan only, no external load
// - 64 scan periods inside 144 period window
// - lines high, then low each two periods
// - preset of line tied to sense used
// - top address line preset is default
// - only 16 positions (lines 0..15) valid, else default
// - lines eight, nine presets disable refresh
// - default preset: all four, 31/30/30/18, late
// - out of reset all phases four
// - odd total gets one extra half period
// - frame strobe every external cycle
// - phase four held while wait asserted
//
// The register addresses and the plain strobed port were decided locally.
`timescale 1ns/1ps
`include "emisc_params.svh"
module emisc_top (
   input wire logic i_sys_clk,
   input wire logic i_reset_n,
   input wire logic i_clockin,
   input wire logic i_config_sense_input,
   input wire logic i_wait,
   input wire logic i_req,
   input wire logic i_req_write,
   input wire logic i_req_onchip,
   input wire logic [29:0] i_req_addr,
   input wire logic [31:0] i_req_data,
   input wire logic [3:0] i_req_byte_en,
   output logic o_req_ready,
   output logic o_done,
   output logic [31:0] o_rd_data,
   input wire logic [31:0] i_bus_in,
   output logic [31:0] o_bus_out,
   output logic [31:0] o_bus_oe,
   output logic o_processor_clock_output,
   output logic o_cycle_frame_strobe_n,
   output logic o_width_prog_strobe_n,
   output logic o_delayed_strobe_a_n,
   output logic o_delayed_strobe_b_n,
   output logic o_delayed_strobe_c_n,
   output logic [3:0] o_byte_write_strobes_n,
   output logic o_cfg_done,
   output logic o_refresh_en,
   output logic [7:0] o_refresh_interval,
   input wire logic [3:0] i_reg_addr,
   input wire logic [31:0] i_reg_wdata,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   output logic [31:0] o_reg_rdata
);
   import emisc_pkg::*;

   typedef struct packed {
      emisc_state_e state;
      logic [2:0] sy1;
      logic [2:0] sy2;
      logic [2:0] sy3;
      logic [2:0] filt;
      logic [7:0] clkin_cnt;
      logic detected;
      logic [4:0] det_line;
      emisc_cfg_s cfg;
      logic ctrl_en;
      logic [2:0] phase_cnt;
      logic [5:0] elapsed;
      logic write;
      logic [3:0] be;
      logic [29:0] addr;
      logic [31:0] data;
      logic [31:0] rd_data;
      logic done;
      logic [31:0] reg_rdata;
      logic proc_clk;
   } emisc_regs_s;

   emisc_regs_s q;
   emisc_regs_s d;

   ////////////////////////////////////////////////////////////////////////////////
   // preset table
   function automatic emisc_cfg_s mk(input logic [2:0] a, input logic [2:0] b,
         input logic [2:0] c, input logic [2:0] e, input logic [2:0] f,
         input logic [2:0] g, input logic [4:0] w1, input logic [4:0] w2,
         input logic [4:0] w3, input logic [4:0] w4, input logic early,
         input logic rf);
      emisc_cfg_s r;
      r = '{t1: a, t2: b, t3: c, t4: e, t5: f, t6: g, s1: w1, s2: w2, s3: w3,
            s4: w4, early: early, refresh_en: rf};
      return r;
   endfunction

   function automatic emisc_cfg_s preset(input logic [4:0] idx);
      emisc_cfg_s r;
      case (idx)
         5'h00: r = mk(3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 5'h1E, 5'h07, 5'h03, 5'h05, 1'b0, 1'b1);
         5'h01: r = mk(3'h1, 3'h2, 3'h1, 3'h1, 3'h1, 3'h2, 5'h1E, 5'h01, 5'h02, 5'h07, 1'b0, 1'b1);
         5'h02: r = mk(3'h1, 3'h2, 3'h1, 3'h1, 3'h2, 3'h3, 5'h1E, 5'h01, 5'h02, 5'h07, 1'b0, 1'b1);
         5'h03: r = mk(3'h2, 3'h3, 3'h1, 3'h1, 3'h2, 3'h3, 5'h1E, 5'h01, 5'h03, 5'h08, 1'b0, 1'b1);
         5'h04: r = mk(3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 5'h03, 5'h01, 5'h02, 5'h03, 1'b1, 1'b1);
         5'h05: r = mk(3'h1, 3'h1, 3'h2, 3'h1, 3'h2, 3'h1, 5'h05, 5'h01, 5'h02, 5'h03, 1'b1, 1'b1);
         5'h06: r = mk(3'h2, 3'h1, 3'h2, 3'h1, 3'h3, 3'h1, 5'h06, 5'h01, 5'h02, 5'h03, 1'b1, 1'b1);
         5'h07: r = mk(3'h2, 3'h2, 3'h2, 3'h1, 3'h3, 3'h2, 5'h07, 5'h01, 5'h03, 5'h04, 1'b1, 1'b1);
         // static ram only, refresh off
         5'h08: r = mk(3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 5'h1E, 5'h01, 5'h02, 5'h03, 1'b1, 1'b0);
         5'h09: r = mk(3'h1, 3'h1, 3'h2, 3'h1, 3'h2, 3'h1, 5'h1E, 5'h02, 5'h05, 5'h09, 1'b1, 1'b0);
         5'h0A: r = mk(3'h2, 3'h2, 3'h2, 3'h2, 3'h4, 3'h2, 5'h1E, 5'h02, 5'h03, 5'h08, 1'b0, 1'b1);
         5'h0B: r = mk(3'h3, 3'h3, 3'h3, 3'h3, 3'h3, 3'h3, 5'h1E, 5'h02, 5'h04, 5'h0D, 1'b0, 1'b1);
         5'h0C: r = mk(3'h1, 3'h1, 3'h2, 3'h1, 3'h2, 3'h1, 5'h04, 5'h01, 5'h02, 5'h03, 1'b1, 1'b1);
         5'h0D: r = mk(3'h2, 3'h1, 3'h2, 3'h1, 3'h2, 3'h2, 5'h05, 5'h01, 5'h02, 5'h03, 1'b1, 1'b1);
         5'h0E: r = mk(3'h2, 3'h2, 3'h2, 3'h1, 3'h3, 3'h2, 5'h06, 5'h01, 5'h03, 5'h04, 1'b1, 1'b1);
         5'h0F: r = mk(3'h2, 3'h1, 3'h2, 3'h3, 3'h3, 3'h3, 5'h08, 5'h01, 5'h02, 5'h03, 1'b1, 1'b1);
         // default: all four, late write
         default: r = mk(3'h4, 3'h4, 3'h4, 3'h4, 3'h4, 3'h4, 5'h1F, 5'h1E, 5'h1E, 5'h12, 1'b0, 1'b1);
      endcase
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // helpers
   logic clkin_rise;
   logic in_frame;
   logic data_phase;
   logic phase_end;
   logic odd_total;
   logic [4:0] det_idx;
   logic [5:0] scan_step;
   logic [31:0] lane_oe;
   logic [31:0] scan_bus;

   assign clkin_rise = (q.sy2[0] == q.sy3[0]) && q.sy3[0] && !q.filt[0];
   assign in_frame = (q.state == ST_P2) || (q.state == ST_P3) || (q.state == ST_P4)
         || (q.state == ST_P5);
   assign data_phase = in_frame && (q.state != ST_P2) || (q.state == ST_P6)
         || (q.state == ST_PE);
   assign phase_end = (q.phase_cnt == 3'h0);
   assign odd_total = q.cfg.t1[0] ^ q.cfg.t2[0] ^ q.cfg.t3[0] ^ q.cfg.t4[0]
         ^ q.cfg.t5[0] ^ q.cfg.t6[0];
   // only 16 positions (lines 0..15) map, others fall back
   assign det_idx = (q.detected && (q.det_line <= 5'(`EMISC_LAST_LOW_LINE))) ? q.det_line
         : 5'(`EMISC_DEFAULT_PRESET);
   assign scan_step = q.clkin_cnt[6:1];

   genvar gi;
   generate
      for (gi = 0; gi < `EMISC_NUM_LINES; gi++) begin : g_line
         // each line falls two periods after the previous
         assign scan_bus[gi] = (q.clkin_cnt < 8'(2 * gi + 1));
         // unwritten lanes float during writes
         assign lane_oe[gi] = q.be[gi / 8];
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      d = q;
      d.done = 1'b0;
      d.proc_clk = ~q.proc_clk;
      d.reg_rdata = 32'h0;
      if (i_reg_rd) begin
         case (i_reg_addr)
            `EMISC_REG_STATUS: d.reg_rdata = {24'h0, q.det_line, q.detected,
                  (q.state != ST_SCAN), (q.state != ST_IDLE)};
            `EMISC_REG_CTRL: d.reg_rdata = {31'h0, q.ctrl_en};
            `EMISC_REG_CFG: d.reg_rdata = q.cfg[31:0];
            default: d.reg_rdata = 32'h0;
         endcase
      end
      if (i_reg_wr && (i_reg_addr == `EMISC_REG_CTRL)) begin
         d.ctrl_en = i_reg_wdata[0];
      end
      if ((q.state != ST_P1) && (q.state != ST_IDLE)) begin
         d.elapsed = (q.elapsed == `EMISC_ELAPSED_MAX) ? q.elapsed : q.elapsed + 6'h1;
      end
      if (!q.phase_cnt[2] || phase_end) begin
         d.phase_cnt = phase_end ? 3'h0 : q.phase_cnt - 3'h1;
      end else begin
         d.phase_cnt = q.phase_cnt - 3'h1;
      end
      case (q.state)
         ST_SCAN: begin
            // internal test first; external load not fitted
            if (clkin_rise) begin
               d.clkin_cnt = q.clkin_cnt + 8'h1;
               if (!q.clkin_cnt[0] && (q.clkin_cnt != 8'h0)
                     && (q.clkin_cnt <= 8'(`EMISC_SCAN_PERIODS)) && !q.detected
                     && !q.filt[1]) begin
                  d.detected = 1'b1;
                  d.det_line = scan_step[4:0] - 5'h1;
               end
               if (q.clkin_cnt == 8'(`EMISC_SCAN_WINDOW - 1)) begin
                  d.cfg = preset(det_idx);
                  d.state = ST_IDLE;
               end
            end
         end
         ST_IDLE: begin
            if (o_req_ready && i_req) begin
               d.write = i_req_write;
               d.be = i_req_byte_en;
               d.addr = i_req_addr;
               d.data = i_req_data;
               d.phase_cnt = q.cfg.t1 - 3'h1;
               d.state = i_req_onchip ? ST_ONCHIP : ST_P1;
            end
         end
         ST_ONCHIP: begin
            d.done = 1'b1;
            d.state = ST_IDLE;
         end
         ST_P1: begin
            if (phase_end) begin
               d.state = ST_P2;
               d.phase_cnt = q.cfg.t2 - 3'h1;
               d.elapsed = 6'h0;
            end
         end
         ST_P2: begin
            if (phase_end) begin
               d.state = ST_P3;
               d.phase_cnt = q.cfg.t3 - 3'h1;
            end
         end
         ST_P3: begin
            if (phase_end) begin
               d.state = ST_P4;
               d.phase_cnt = q.cfg.t4 - 3'h1;
            end
         end
         ST_P4: begin
            // waits extend phase four at its end
            if (phase_end && !q.filt[2]) begin
               d.state = ST_P5;
               d.phase_cnt = q.cfg.t5 - 3'h1;
            end
         end
         ST_P5: begin
            if (phase_end) begin
               d.rd_data = i_bus_in;
               d.state = ST_P6;
               d.phase_cnt = q.cfg.t6 - 3'h1;
            end
         end
         ST_P6: begin
            if (phase_end) begin
               d.state = odd_total ? ST_PE : ST_IDLE;
               d.done = !odd_total;
            end
         end
         ST_PE: begin
            d.done = 1'b1;
            d.state = ST_IDLE;
         end
         default: d.state = ST_IDLE;
      endcase
      if (!i_reset_n) begin
         d = '0;
         d.state = ST_SCAN;
         d.cfg = preset(5'(`EMISC_DEFAULT_PRESET));
         d.ctrl_en = `EMISC_CTRL_RESET;
      end
      d.sy1 = {i_wait, i_config_sense_input, i_clockin};
      d.sy2 = q.sy1;
      d.sy3 = q.sy2;
      for (int k = 0; k < 3; k++) begin
         d.filt[k] = (q.sy2[k] == q.sy3[k]) ? q.sy3[k] : q.filt[k];
      end
   end

   always_ff @(posedge i_sys_clk) begin
      q <= d;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // outputs
   assign o_req_ready = (q.state == ST_IDLE) && q.ctrl_en && !q.proc_clk;
   assign o_done = q.done;
   assign o_rd_data = q.rd_data;
   assign o_reg_rdata = q.reg_rdata;
   assign o_processor_clock_output = q.proc_clk;
   assign o_cfg_done = (q.state != ST_SCAN);
   assign o_refresh_en = q.cfg.refresh_en;
   assign o_refresh_interval = q.cfg.refresh_en ? 8'(`EMISC_REFRESH_IVL) : 8'h0;
   assign o_cycle_frame_strobe_n = !in_frame;
   // width strobe from phase two, cut at end of six
   assign o_width_prog_strobe_n = !((in_frame || (q.state == ST_P6))
         && (q.elapsed < 6'(q.cfg.s1)));
   // delayed strobes end with phase five; zero disables
   assign o_delayed_strobe_a_n = !(in_frame && (q.cfg.s2 != 5'h0)
         && (q.elapsed >= 6'(q.cfg.s2)));
   assign o_delayed_strobe_b_n = !(in_frame && (q.cfg.s3 != 5'h0)
         && (q.elapsed >= 6'(q.cfg.s3)));
   assign o_delayed_strobe_c_n = !(in_frame && (q.cfg.s4 != 5'h0)
         && (q.elapsed >= 6'(q.cfg.s4)));
   // late: four and five, early adds three; not on-chip
   assign o_byte_write_strobes_n = ~(q.be & {4{q.write && ((q.state == ST_P4)
         || (q.state == ST_P5) || (q.cfg.early && (q.state == ST_P3)))}});

   always_comb begin
      o_bus_out = 32'h0;
      o_bus_oe = 32'h0;
      case (q.state)
         ST_SCAN: begin
            if (q.clkin_cnt <= 8'(`EMISC_SCAN_PERIODS)) begin
               o_bus_out = scan_bus;
               o_bus_oe = 32'hFFFFFFFF;
            end
         end
         ST_P1, ST_P2, ST_ONCHIP: begin
            o_bus_out = {q.addr, 1'b1, !q.write};
            o_bus_oe = 32'hFFFFFFFF;
         end
         default: begin
            // write data held to end of six and the extra period
            if (data_phase && q.write) begin
               o_bus_out = q.data;
               o_bus_oe = lane_oe;
            end
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // checks
   property p_frame;
      @(posedge i_sys_clk) disable iff (!i_reset_n)
      (q.state == ST_P2) |-> !o_cycle_frame_strobe_n
            && (($past(q.state) == ST_P1) || ($past(q.state) == ST_P2));
   endproperty
   a_frame: assert property (p_frame) else $error("frame strobe not low in phase two");

   property p_wait;
      @(posedge i_sys_clk) disable iff (!i_reset_n)
      (q.state == ST_P4 && phase_end && q.filt[2]) |=> (q.state == ST_P4);
   endproperty
   a_wait: assert property (p_wait) else $error("wait did not hold phase four");

   property p_even;
      @(posedge i_sys_clk) disable iff (!i_reset_n)
      (q.state == ST_P6 && phase_end && odd_total) |=> (q.state == ST_PE) ##1 q.done;
   endproperty
   a_even: assert property (p_even) else $error("odd cycle not padded");

   property p_dly_end;
      @(posedge i_sys_clk) disable iff (!i_reset_n)
      (q.state == ST_P6) |-> (o_delayed_strobe_a_n && o_delayed_strobe_b_n
            && o_delayed_strobe_c_n && o_cycle_frame_strobe_n);
   endproperty
   a_dly_end: assert property (p_dly_end) else $error("delayed strobe past phase five");

   property p_s1_zero;
      @(posedge i_sys_clk) disable iff (!i_reset_n)
      (q.cfg.s1 == 5'h0) |-> o_width_prog_strobe_n;
   endproperty
   a_s1_zero: assert property (p_s1_zero) else $error("zero width strobe went low");

   property p_onchip;
      @(posedge i_sys_clk) disable iff (!i_reset_n)
      (q.state == ST_ONCHIP) |-> (o_byte_write_strobes_n == 4'hF) ##1 (q.state == ST_IDLE);
   endproperty
   a_onchip: assert property (p_onchip) else $error("write strobe on on-chip cycle");

   property p_late;
      @(posedge i_sys_clk) disable iff (!i_reset_n)
      (q.state == ST_P3 && !q.cfg.early) |-> (o_byte_write_strobes_n == 4'hF);
   endproperty
   a_late: assert property (p_late) else $error("late write strobe in phase three");

   property p_lane;
      @(posedge i_sys_clk) disable iff (!i_reset_n)
      (q.write && q.state == ST_P5 && !q.be[1]) |-> (o_bus_oe[15:8] == 8'h0)
            && !o_byte_write_strobes_n[0] == q.be[0];
   endproperty
   a_lane: assert property (p_lane) else $error("unwritten lane driven");

   property p_scan_start;
      @(posedge i_sys_clk) disable iff (!i_reset_n)
      (q.state == ST_SCAN && q.clkin_cnt == 8'h0) |-> (o_bus_out == 32'hFFFFFFFF)
            && (o_bus_oe == 32'hFFFFFFFF);
   endproperty
   a_scan_start: assert property (p_scan_start) else $error("scan lines not all high");

   property p_default;
      @(posedge i_sys_clk) disable iff (!i_reset_n)
      $rose(o_cfg_done) && !q.detected |-> (q.cfg.t1 == 3'h4) && (q.cfg.s1 == 5'h1F);
   endproperty
   a_default: assert property (p_default) else $error("default preset not loaded");

   c_write: cover property (@(posedge i_sys_clk) disable iff (!i_reset_n)
         (q.state == ST_P5) && q.write);
   c_wait: cover property (@(posedge i_sys_clk) disable iff (!i_reset_n)
         (q.state == ST_P4) && q.filt[2] ##1 (q.state == ST_P4));
   c_detect: cover property (@(posedge i_sys_clk) disable iff (!i_reset_n)
         $rose(o_cfg_done) && q.detected);
endmodule // emisc_top

/* File: core/emisc_params.svh */
// timing, scan and register constants for the memory strobe and config scan block
`ifndef EMISC_PARAMS_SVH
`define EMISC_PARAMS_SVH
`define EMISC_NUM_LINES 32
`define EMISC_SCAN_STEP 2
`define EMISC_SCAN_PERIODS 64
`define EMISC_SCAN_WINDOW 144
`define EMISC_NUM_PRESETS 17
`define EMISC_DEFAULT_PRESET 16
`define EMISC_LAST_LOW_LINE 15
`define EMISC_REFRESH_IVL 72
`define EMISC_DUR_MAX 4
`define EMISC_ELAPSED_MAX 6'h3F
`define EMISC_REG_STATUS 4'h0
`define EMISC_REG_CTRL 4'h4
`define EMISC_REG_CFG 4'h8
`define EMISC_CTRL_RESET 1'b1
`endif

/* File: core/emisc_pkg.sv */
// types shared by the memory strobe and config scan block
package emisc_pkg;
   typedef enum logic [3:0] {
      ST_SCAN = 4'h0,
      ST_IDLE = 4'h1,
      ST_P1 = 4'h2,
      ST_P2 = 4'h3,
      ST_P3 = 4'h4,
      ST_P4 = 4'h5,
      ST_P5 = 4'h6,
      ST_P6 = 4'h7,
      ST_PE = 4'h8,
      ST_ONCHIP = 4'h9
   } emisc_state_e;

   typedef struct packed {
      logic [2:0] t1;
      logic [2:0] t2;
      logic [2:0] t3;
      logic [2:0] t4;
      logic [2:0] t5;
      logic [2:0] t6;
      logic [4:0] s1;
      logic [4:0] s2;
      logic [4:0] s3;
      logic [4:0] s4;
      logic early;
      logic refresh_en;
   } emisc_cfg_s;
endpackage

/* File: verif/emisc_mem_model.sv */
// memory and wait model on the far side of the strobe block
`timescale 1ns/1ps
module emisc_mem_model (
   input wire logic i_clk,
   input wire logic i_slow,
   input wire logic [31:0] i_bus_out,
   input wire logic [31:0] i_bus_oe,
   input wire logic i_frame_n,
   input wire logic [3:0] i_wr_n,
   output logic [31:0] o_bus_in,
   output logic o_wait
);
   logic [31:0] mem [16];
   logic [31:0] last_q = 32'h0;
   logic [3:0] adr = 4'h0;
   logic [3:0] wr_q = 4'hF;
   logic fr_q = 1'b1;
   int cnt = 0;
   initial begin
      for (int i = 0; i < 16; i++) mem[i] = 32'h0;
   end
   // released bus in a frame shows memory; otherwise it shows the inverse of the last value
   assign o_bus_in = (!i_frame_n && i_bus_oe == 32'h0) ? mem[adr] : ~last_q;
   assign o_wait = i_slow && !i_frame_n && cnt < 24;
   always @(posedge i_clk) begin
      last_q <= o_bus_in;
      fr_q <= i_frame_n;
      wr_q <= i_wr_n;
      cnt <= i_frame_n ? 0 : cnt + 1;
      if (fr_q && !i_frame_n) adr <= i_bus_out[5:2];
      for (int b = 0; b < 4; b++) begin
         if (!wr_q[b] && i_wr_n[b]) mem[adr][8*b+:8] <= i_bus_out[8*b+:8];
      end
   end
endmodule // emisc_mem_model

/* File: verif/emisc_top_tb_top.sv */
// self-checking bench for the memory strobe and config scan block
`timescale 1ns/1ps
module emisc_top_tb_top;
   import emisc_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic clkin = 1'b0;
   logic req = 1'b0, wr = 1'b0, onchip = 1'b0, slow = 1'b0;
   logic reg_wr = 1'b0, reg_rd = 1'b0;
   logic [29:0] addr = 30'h0;
   logic [31:0] wdata = 32'h0, reg_wdata = 32'h0, got;
   logic [3:0] be = 4'hF, reg_addr = 4'h0;
   logic [5:0] sel = 6'h3F;
   logic sense, wt, ready, done, fr_n, w_n, a_n, b_n, c_n, cfg_done, rf_en;
   logic [31:0] bus_in, bus_out, bus_oe, rd_data, reg_rdata;
   logic [3:0] wr_n;
   logic [7:0] rf_ivl;
   int failures = 0, total_checks = 0, cycles = 0;
   int n, n_fr, n_w, n_a, n_c, n_ws, n_lane, n_oc;
   // line, frame, width, delay a, delay c, write, cycle, refresh
   int rows [19][8] = '{'{0, 4, 5, 0, 0, 2, 3, 1}, '{1, 5, 7, 4, 0, 2, 4, 1},
      '{2, 6, 9, 5, 0, 3, 5, 1}, '{3, 7, 10, 6, 0, 3, 6, 1}, '{4, 4, 3, 3, 1, 3, 3, 1},
      '{5, 6, 5, 5, 3, 5, 4, 1}, '{6, 7, 6, 6, 4, 6, 5, 1}, '{7, 8, 7, 7, 4, 6, 6, 1},
      '{8, 4, 5, 3, 1, 3, 3, 0}, '{9, 6, 7, 4, 0, 5, 4, 0}, '{10, 10, 12, 8, 2, 6, 7, 1},
      '{11, 12, 15, 10, 0, 6, 9, 1}, '{12, 6, 4, 5, 3, 5, 4, 1}, '{13, 6, 5, 5, 3, 5, 5, 1},
      '{14, 8, 6, 7, 4, 6, 6, 1}, '{15, 9, 8, 8, 6, 8, 7, 1}, '{31, 16, 20, 0, 0, 8, 12, 1},
      '{20, 16, 20, 0, 0, 8, 12, 1}, '{63, 16, 20, 0, 0, 8, 12, 1}};
   always #12.5 clk = ~clk;
   always #100 clkin = ~clkin;
   // sense pin strapped to one scanned line, pulled up when released
   assign sense = (sel == 6'h3F) ? 1'b1 : (bus_oe[sel[4:0]] ? bus_out[sel[4:0]] : 1'b1);
   emisc_top dut_u (.i_sys_clk(clk), .i_reset_n(rst_n), .i_clockin(clkin),
      .i_config_sense_input(sense), .i_wait(wt), .i_req(req), .i_req_write(wr),
      .i_req_onchip(onchip), .i_req_addr(addr), .i_req_data(wdata), .i_req_byte_en(be),
      .o_req_ready(ready), .o_done(done), .o_rd_data(rd_data), .i_bus_in(bus_in),
      .o_bus_out(bus_out), .o_bus_oe(bus_oe), .o_processor_clock_output(),
      .o_cycle_frame_strobe_n(fr_n), .o_width_prog_strobe_n(w_n),
      .o_delayed_strobe_a_n(a_n), .o_delayed_strobe_b_n(b_n), .o_delayed_strobe_c_n(c_n),
      .o_byte_write_strobes_n(wr_n), .o_cfg_done(cfg_done), .o_refresh_en(rf_en),
      .o_refresh_interval(rf_ivl), .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata),
      .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .o_reg_rdata(reg_rdata));
   emisc_mem_model mem_u (.i_clk(clk), .i_slow(slow), .i_bus_out(bus_out),
      .i_bus_oe(bus_oe), .i_frame_n(fr_n), .i_wr_n(wr_n), .o_bus_in(bus_in), .o_wait(wt));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic wrap_up;
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e) begin
         failures++;
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 40000) begin
         failures++;
         wrap_up();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic reg_acc(input logic w, input logic [3:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= w;
      reg_rd <= !w;
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      @(negedge clk);
      got = reg_rdata;
      @(posedge clk);
   endtask
   task automatic mem_cyc(input logic w, input logic oc, input logic [3:0] b,
                          input logic [31:0] d);
      {n, n_fr, n_w, n_a, n_c, n_ws, n_lane, n_oc} = '0;
      req <= 1'b1;
      wr <= w;
      onchip <= oc;
      be <= b;
      wdata <= d;
      do begin
         @(negedge clk);
         n++;
      end while (ready !== 1'b1 && n < 200);
      chk(ready, 32'h1);
      @(posedge clk);
      req <= 1'b0;
      n = 0;
      do begin
         @(negedge clk);
         n++;
         n_fr += !fr_n;
         n_w += !w_n;
         n_a += !a_n;
         n_c += !c_n;
         n_ws += !wr_n[0];
         n_lane += !b[1] && (wr_n[1] !== 1'b1 || (wr_n[0] === 1'b0 && bus_oe[15:8] !== 8'h0));
         n_oc += oc && (wr_n !== 4'hF || fr_n !== 1'b1);
      end while (done !== 1'b1 && n < 400);
      chk(done, 32'h1);
      @(posedge clk);
   endtask
   task automatic scan(input logic [5:0] s);
      sel <= s;
      rst_n <= 1'b0;
      repeat (5) @(posedge clk);
      chk(fr_n & w_n & c_n & (&wr_n), 32'h1);
      chk(bus_oe, 32'hFFFFFFFF);
      chk({ready, cfg_done}, 32'h0);
      rst_n <= 1'b1;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (cfg_done !== 1'b1 && n < 1400);
      @(posedge clk);
      chk(n >= 1140 && n <= 1180, 32'h1);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      for (int r = 0; r < 19; r++) begin
         scan(6'(rows[r][0]));
         reg_acc(1'b0, 4'h0, 32'h0);
         if (r < 17) chk(got[7:2], {5'(rows[r][0]), 1'b1});
         chk({rf_en, rf_ivl}, (rows[r][7] != 0) ? 32'h148 : 32'h0);
         mem_cyc(1'b1, 1'b0, 4'hF, 32'h5A00 + r);
         chk(n_ws, rows[r][5]);
         chk(n, 2 * rows[r][6] + 1);
         mem_cyc(1'b0, 1'b0, 4'hF, 32'h0);
         chk(n_fr, rows[r][1]);
         chk(n_w, rows[r][2]);
         chk(n_a, rows[r][3]);
         chk(n_c, rows[r][4]);
         chk(rd_data, 32'h5A00 + r);
         $display("row %0d done", r);
      end
      mem_cyc(1'b1, 1'b0, 4'h5, 32'hA1B2C3D4);
      chk(n_lane, 0);
      mem_cyc(1'b0, 1'b0, 4'hF, 32'h0);
      chk(rd_data, 32'h00B25AD4);
      $display("partial write done");
      mem_cyc(1'b1, 1'b1, 4'hF, 32'h0);
      chk(n_oc, 0);
      chk(n, 32'h2);
      $display("on-chip cycle done");
      slow <= 1'b1;
      mem_cyc(1'b0, 1'b0, 4'hF, 32'h0);
      slow <= 1'b0;
      chk(n_fr > 16, 32'h1);
      chk(n_w, (n_fr + 4 < 31) ? n_fr + 4 : 31);
      chk(n_c, n_fr - 18);
      chk(n_a, (n_fr > 30) ? n_fr - 30 : 0);
      chk(rd_data, 32'h00B25AD4);
      $display("wait cycle done");
      reg_acc(1'b0, 4'h8, 32'h0);
      chk(got, 32'h493FEF49);
      reg_acc(1'b0, 4'h4, 32'h0);
      chk(got[0], 1'b1);
      reg_acc(1'b1, 4'h4, 32'h0);
      req <= 1'b1;
      repeat (20) @(posedge clk);
      chk(ready, 1'b0);
      req <= 1'b0;
      reg_acc(1'b1, 4'h4, 32'h1);
      reg_acc(1'b0, 4'hC, 32'h0);
      chk(got, 32'h0);
      $display("register tests done");
      wrap_up();
   end
endmodule // emisc_top_tb_top
